//--- design/urb_pkg.sv
package urb_pkg;

  localparam int CH_N = 4;
  localparam int DEPTH = 16;
  localparam int CNT_W = 5;
  localparam int PTR_W = 4;

  // register offsets inside one channel
  localparam logic [2:0] OFS_HOLD = 3'h0;
  localparam logic [2:0] OFS_MASK = 3'h1;
  localparam logic [2:0] OFS_SETUP = 3'h2;
  localparam logic [2:0] OFS_FORMAT = 3'h3;
  localparam logic [2:0] OFS_MODEM = 3'h4;
  localparam logic [2:0] OFS_LSTATE = 3'h5;
  localparam logic [2:0] OFS_MSTATE = 3'h6;
  localparam logic [2:0] OFS_SCRATCH = 3'h7;

  // field positions
  localparam int SETUP_EN = 0;
  localparam int SETUP_RXCLR = 1;
  localparam int SETUP_TXCLR = 2;
  localparam int SETUP_BLOCK = 3;
  localparam int SETUP_TXTRIG = 4;
  localparam int SETUP_RXTRIG = 6;
  localparam int FORMAT_DLAB = 7;
  localparam int MODEM_PRESC = 7;
  localparam int LS_DREADY = 0;
  localparam int LS_HOLD_EMPTY = 5;
  localparam int LS_TX_EMPTY = 6;

  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [15:0] RST_DIV = 16'h0000;

  // interrupt source codes
  localparam logic [3:0] SRC_NONE = 4'h1;
  localparam logic [3:0] SRC_TX = 4'h2;
  localparam logic [3:0] SRC_RX = 4'h4;
  localparam logic [3:0] SRC_TOUT = 4'hc;

  // trigger levels selected by a 2-bit field
  localparam logic [4:0] TRIG_0 = 5'h01;
  localparam logic [4:0] TRIG_1 = 5'h04;
  localparam logic [4:0] TRIG_2 = 5'h08;
  localparam logic [4:0] TRIG_3 = 5'h0e;

  // timing in sample ticks
  localparam int SAMPLES_PER_BIT = 16;
  localparam int TOUT_WORDS = 4;
  localparam int TOUT_EXTRA_BITS = 12;
  localparam int WORD_BITS_BASE = 5;
  localparam logic [1:0] PRESC_LAST = 2'h3;

  typedef struct packed {
    logic tx_take;
    logic tx_shift_busy;
    logic rx_put;
    logic [7:0] rx_byte;
  } urb_srl_in_s;

  typedef struct packed {
    logic irq_tx;
    logic irq_rx;
    logic rx_service_req_n;
    logic tx_service_req_n;
    logic sample_tick;
    logic tx_avail;
    logic [7:0] tx_byte;
  } urb_chan_out_s;

endpackage : urb_pkg

//--- design/urb_quad_ready_baud.sv
module urb_quad_ready_baud #(
  parameter int CH_N = urb_pkg::CH_N,
  parameter int DEPTH = urb_pkg::DEPTH
) (
  input logic ref_clk,
  input logic rstn,
  input logic [4:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [7:0] reg_rdata,
  input logic osc_in,
  output logic osc_out,
  input urb_pkg::urb_srl_in_s serial_in [CH_N],
  output urb_pkg::urb_chan_out_s chan_out [CH_N]
);

  logic [7:0] ch_rd_val [CH_N];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      osc_out <= 1'b0;
    end else begin
      osc_out <= ~osc_in;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= urb_pkg::RST_REG;
    end else if (reg_rd) begin
      reg_rdata <= ch_rd_val[reg_addr[4:3]];
    end else begin
      reg_rdata <= urb_pkg::RST_REG;
    end
  end

  function automatic logic [4:0] urb_trig(input logic [1:0] sel);
    case (sel)
      2'h0: urb_trig = urb_pkg::TRIG_0;
      2'h1: urb_trig = urb_pkg::TRIG_1;
      2'h2: urb_trig = urb_pkg::TRIG_2;
      default: urb_trig = urb_pkg::TRIG_3;
    endcase
  endfunction

  genvar ch;
  for (ch = 0; ch < CH_N; ch++) begin : g_ch
    logic sel;
    logic wr;
    logic rd;
    logic dlab;
    logic fifo_en;
    logic blk;
    logic [7:0] setup;
    logic [7:0] mask;
    logic [7:0] format;
    logic [7:0] modem;
    logic [7:0] scratch;
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic [15:0] divisor;
    logic [7:0] tmem [DEPTH];
    logic [7:0] rmem [DEPTH];
    logic [3:0] twp;
    logic [3:0] trp;
    logic [3:0] rwp;
    logic [3:0] rrp;
    logic [4:0] tcnt;
    logic [4:0] rcnt;
    logic [4:0] cap;
    logic [4:0] ttrig;
    logic [4:0] rtrig;
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic clr_tx;
    logic clr_rx;
    logic [4:0] next_tcnt;
    logic [3:0] next_trp;
    logic [1:0] pre_cnt;
    logic [15:0] div_cnt;
    logic tick;
    logic [9:0] tout_cnt;
    logic [9:0] tout_lim;
    logic tout;
    logic [3:0] src;
    logic [7:0] lstate;

    assign sel = (reg_addr[4:3] == 2'(ch));
    assign wr = reg_wr & sel;
    assign rd = reg_rd & sel;
    assign dlab = format[urb_pkg::FORMAT_DLAB];
    assign fifo_en = setup[urb_pkg::SETUP_EN];
    assign blk = fifo_en & setup[urb_pkg::SETUP_BLOCK];
    assign divisor = {div_hi, div_lo};
    // fifos off behave as one-deep holding registers
    assign cap = fifo_en ? 5'(DEPTH) : 5'h01;
    assign ttrig = urb_trig(setup[urb_pkg::SETUP_TXTRIG +: 2]);
    assign rtrig = urb_trig(setup[urb_pkg::SETUP_RXTRIG +: 2]);

    assign tx_push = wr & (reg_addr[2:0] == urb_pkg::OFS_HOLD) & !dlab & (tcnt < cap);
    assign tx_pop = serial_in[ch].tx_take & (tcnt != 5'h00);
    assign rx_push = serial_in[ch].rx_put & (rcnt < cap);
    assign rx_pop = rd & (reg_addr[2:0] == urb_pkg::OFS_HOLD) & !dlab & (rcnt != 5'h00);
    assign clr_tx = wr & (reg_addr[2:0] == urb_pkg::OFS_SETUP)
      & (reg_wdata[urb_pkg::SETUP_TXCLR] | (reg_wdata[urb_pkg::SETUP_EN] != fifo_en));
    assign clr_rx = wr & (reg_addr[2:0] == urb_pkg::OFS_SETUP)
      & (reg_wdata[urb_pkg::SETUP_RXCLR] | (reg_wdata[urb_pkg::SETUP_EN] != fifo_en));
    assign next_tcnt = clr_tx ? 5'h00 : 5'(tcnt + 5'(tx_push) - 5'(tx_pop));
    assign next_trp = clr_tx ? 4'h0 : 4'(trp + 4'(tx_pop));

    // control registers; divisor is reset here only so the sim is defined
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        setup <= urb_pkg::RST_REG;
        mask <= urb_pkg::RST_REG;
        format <= urb_pkg::RST_REG;
        modem <= urb_pkg::RST_REG;
        scratch <= urb_pkg::RST_REG;
        div_lo <= urb_pkg::RST_DIV[7:0];
        div_hi <= urb_pkg::RST_DIV[15:8];
      end else if (wr) begin
        case (reg_addr[2:0])
          urb_pkg::OFS_HOLD: begin
            if (dlab) begin
              div_lo <= reg_wdata;
            end
          end
          urb_pkg::OFS_MASK: begin
            if (dlab) begin
              div_hi <= reg_wdata;
            end else begin
              mask <= reg_wdata;
            end
          end
          // clear bits are self-clearing, never stored
          urb_pkg::OFS_SETUP: setup <= reg_wdata & 8'hf9;
          urb_pkg::OFS_FORMAT: format <= reg_wdata;
          urb_pkg::OFS_MODEM: modem <= reg_wdata;
          urb_pkg::OFS_SCRATCH: scratch <= reg_wdata;
          default: ;
        endcase
      end
    end

    // transmit storage
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        twp <= 4'h0;
        trp <= 4'h0;
        tcnt <= 5'h00;
      end else begin
        twp <= clr_tx ? 4'h0 : 4'(twp + 4'(tx_push));
        trp <= next_trp;
        tcnt <= next_tcnt;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (tx_push) begin
        tmem[twp] <= reg_wdata;
      end
    end

    // receive storage
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        rwp <= 4'h0;
        rrp <= 4'h0;
        rcnt <= 5'h00;
      end else if (clr_rx) begin
        rwp <= 4'h0;
        rrp <= 4'h0;
        rcnt <= 5'h00;
      end else begin
        rwp <= 4'(rwp + 4'(rx_push));
        rrp <= 4'(rrp + 4'(rx_pop));
        rcnt <= 5'(rcnt + 5'(rx_push) - 5'(rx_pop));
      end
    end

    always_ff @(posedge ref_clk) begin
      if (rx_push) begin
        rmem[rwp] <= serial_in[ch].rx_byte;
      end
    end

    // rate divider; a zero divisor stops the tick
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        pre_cnt <= 2'h0;
        div_cnt <= 16'h0000;
        tick <= 1'b0;
      end else begin
        tick <= 1'b0;
        if (divisor == 16'h0000) begin
          pre_cnt <= 2'h0;
          div_cnt <= 16'h0000;
        end else if (pre_cnt == (modem[urb_pkg::MODEM_PRESC] ? urb_pkg::PRESC_LAST : 2'h0)) begin
          pre_cnt <= 2'h0;
          if (div_cnt >= 16'(divisor - 16'h0001)) begin
            div_cnt <= 16'h0000;
            tick <= 1'b1;
          end else begin
            div_cnt <= 16'(div_cnt + 16'h0001);
          end
        end else begin
          pre_cnt <= 2'(pre_cnt + 2'h1);
        end
      end
    end

    assign tout_lim = 10'(((urb_pkg::WORD_BITS_BASE + int'(format[1:0])) * urb_pkg::TOUT_WORDS
      + urb_pkg::TOUT_EXTRA_BITS) * urb_pkg::SAMPLES_PER_BIT - 1);

    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        tout_cnt <= 10'h000;
        tout <= 1'b0;
      end else if (rx_push | rx_pop | clr_rx | (rcnt == 5'h00)) begin
        tout_cnt <= 10'h000;
        tout <= 1'b0;
      end else if (tick) begin
        if (tout_cnt >= tout_lim) begin
          tout <= 1'b1;
        end else begin
          tout_cnt <= 10'(tout_cnt + 10'h001);
        end
      end
    end

    // ready outputs only, no memory master
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        chan_out[ch].irq_tx <= 1'b1;
        chan_out[ch].irq_rx <= 1'b0;
        chan_out[ch].rx_service_req_n <= 1'b1;
        chan_out[ch].tx_service_req_n <= 1'b0;
      end else begin
        if (fifo_en) begin
          chan_out[ch].irq_tx <= !(next_tcnt > ttrig);
          chan_out[ch].irq_rx <= (rcnt >= rtrig) | tout;
        end else begin
          chan_out[ch].irq_tx <= (next_tcnt == 5'h00);
          chan_out[ch].irq_rx <= (rcnt != 5'h00);
        end
        if (blk) begin
          // fall at trigger, rise on empty
          if (rcnt == 5'h00) begin
            chan_out[ch].rx_service_req_n <= 1'b1;
          end else if ((rcnt >= rtrig) | tout) begin
            chan_out[ch].rx_service_req_n <= 1'b0;
          end
          chan_out[ch].tx_service_req_n <= (next_tcnt == 5'(DEPTH));
        end else begin
          chan_out[ch].rx_service_req_n <= (rcnt == 5'h00);
          chan_out[ch].tx_service_req_n <= (next_tcnt != 5'h00);
        end
      end
    end

    // tick shared by shifter and sampler
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        chan_out[ch].sample_tick <= 1'b0;
        chan_out[ch].tx_avail <= 1'b0;
        chan_out[ch].tx_byte <= urb_pkg::RST_REG;
      end else begin
        chan_out[ch].sample_tick <= tick;
        chan_out[ch].tx_avail <= (next_tcnt != 5'h00);
        // an entry pushed into an emptying store bypasses the array
        if (tx_push && (5'(tcnt - 5'(tx_pop)) == 5'h00)) begin
          chan_out[ch].tx_byte <= reg_wdata;
        end else begin
          chan_out[ch].tx_byte <= tmem[next_trp];
        end
      end
    end

    always_comb begin
      if ((rcnt != 5'h00) & tout) begin
        src = urb_pkg::SRC_TOUT;
      end else if (rcnt != 5'h00) begin
        src = urb_pkg::SRC_RX;
      end else if (tcnt == 5'h00) begin
        src = urb_pkg::SRC_TX;
      end else begin
        src = urb_pkg::SRC_NONE;
      end
    end

    always_comb begin
      lstate = 8'h00;
      lstate[urb_pkg::LS_DREADY] = (rcnt != 5'h00);
      lstate[urb_pkg::LS_HOLD_EMPTY] = (tcnt == 5'h00);
      lstate[urb_pkg::LS_TX_EMPTY] = (tcnt == 5'h00) & !serial_in[ch].tx_shift_busy;
    end

    always_comb begin
      case (reg_addr[2:0])
        urb_pkg::OFS_HOLD: ch_rd_val[ch] = dlab ? div_lo : rmem[rrp];
        urb_pkg::OFS_MASK: ch_rd_val[ch] = dlab ? div_hi : mask;
        urb_pkg::OFS_SETUP: ch_rd_val[ch] = {fifo_en, fifo_en, 2'h0, src};
        urb_pkg::OFS_FORMAT: ch_rd_val[ch] = format;
        urb_pkg::OFS_MODEM: ch_rd_val[ch] = modem;
        urb_pkg::OFS_LSTATE: ch_rd_val[ch] = lstate;
        urb_pkg::OFS_SCRATCH: ch_rd_val[ch] = scratch;
        default: ch_rd_val[ch] = 8'h00;
      endcase
    end
  end

endmodule // urb_quad_ready_baud

//--- test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic osc_in = 1'b0;
  logic [7:0] reg_rdata;
  logic osc_out;
  urb_pkg::urb_srl_in_s serial_in [urb_pkg::CH_N];
  urb_pkg::urb_chan_out_s chan_out [urb_pkg::CH_N];
  int n_fail = 0;
  int checks = 0;
  int i;
  int j;
  int n;
  logic [7:0] d;
  logic [15:0] dv [3] = '{16'h0003, 16'h0003, 16'h0100};
  int pr [3] = '{3, 12, 256};
  urb_quad_ready_baud i_urb_quad_ready_baud (.ref_clk(ref_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .osc_in(osc_in), .osc_out(osc_out),
    .serial_in(serial_in), .chan_out(chan_out));
  urb_serial_model #(.CH_N(urb_pkg::CH_N)) i_urb_serial_model (.ref_clk(ref_clk),
    .serial_in(serial_in));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // free-running external clock at the oscillator pin
  always @(posedge ref_clk) begin
    osc_in <= ~osc_in;
  end
  task report_and_stop;
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task bust;
    n_fail++;
    $display("Error %0t wait expired", $time);
    report_and_stop;
  endtask
  task cmp(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t got %h want %h", $time, g, e);
    end
  endtask
  // flags in order irq_tx, irq_rx, rx ready, tx ready; an extra edge covers latency
  task flg(input int c, input logic [3:0] e);
    @(posedge ref_clk);
    #1;
    cmp({12'h000, chan_out[c].irq_tx, chan_out[c].irq_rx, chan_out[c].rx_service_req_n,
      chan_out[c].tx_service_req_n}, {12'h000, e});
  endtask
  task wr(input logic [1:0] c, input logic [2:0] o, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= {c, o};
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [1:0] c, input logic [2:0] o, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= {c, o};
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task tick(output int k);
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
      if (k > 3000) begin
        bust;
      end
    end while (chan_out[0].sample_tick !== 1'b1);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    flg(0, 4'b1010);
    rd(0, 5, d);
    cmp({8'h00, d & 8'h61}, 16'h0060);
    wr(0, 0, 8'ha5);
    flg(0, 4'b0011);
    cmp({8'h00, chan_out[0].tx_byte}, 16'h00a5);
    rd(0, 5, d);
    cmp({8'h00, d & 8'h61}, 16'h0000);
    i_urb_serial_model.take(0);
    flg(0, 4'b1010);
    // shifter still busy: room for data but transmitter not yet empty
    i_urb_serial_model.busy(0, 1'b1);
    rd(0, 5, d);
    cmp({8'h00, d & 8'h61}, 16'h0020);
    i_urb_serial_model.busy(0, 1'b0);
    i_urb_serial_model.put(0, 8'h3c);
    flg(0, 4'b1100);
    rd(0, 0, d);
    cmp({8'h00, d}, 16'h003c);
    flg(0, 4'b1010);
    wr(0, 2, 8'h41);
    for (i = 0; i < 3; i++) i_urb_serial_model.put(0, 8'h10 + 8'(i));
    flg(0, 4'b1000);
    i_urb_serial_model.put(0, 8'h13);
    flg(0, 4'b1100);
    wr(0, 0, 8'h01);
    wr(0, 0, 8'h02);
    flg(0, 4'b0101);
    // both clear bits set so block mode starts from empty stores
    wr(0, 2, 8'h4f);
    for (i = 0; i < 3; i++) i_urb_serial_model.put(0, 8'h10 + 8'(i));
    flg(0, 4'b1010);
    i_urb_serial_model.put(0, 8'h13);
    flg(0, 4'b1100);
    for (i = 0; i < 4; i++) begin
      rd(0, 0, d);
      cmp({8'h00, d}, 16'h0010 + 16'(i));
      flg(0, i < 3 ? 4'b1000 : 4'b1010);
    end
    for (i = 0; i < 15; i++) wr(0, 0, 8'(i));
    flg(0, 4'b0010);
    wr(0, 0, 8'h0f);
    wr(0, 0, 8'hee);
    flg(0, 4'b0011);
    i_urb_serial_model.take(0);
    flg(0, 4'b0010);
    cmp({8'h00, chan_out[0].tx_byte}, 16'h0001);
    wr(0, 6, 8'hff);
    rd(0, 6, d);
    cmp({8'h00, d}, 16'h0000);
    wr(0, 7, 8'h5a);
    rd(0, 7, d);
    cmp({8'h00, d}, 16'h005a);
    for (j = 0; j < 3; j++) begin
      // the divisor keeps its earlier value, so both bytes are always written
      wr(0, 3, 8'h80);
      wr(0, 0, dv[j][7:0]);
      wr(0, 1, dv[j][15:8]);
      wr(0, 3, 8'h03);
      wr(0, 4, j == 1 ? 8'h80 : 8'h00);
      tick(n);
      tick(n);
      tick(n);
      cmp(16'(n), 16'(pr[j]));
    end
    wr(0, 3, 8'h80);
    wr(0, 0, 8'h01);
    wr(0, 1, 8'h00);
    wr(0, 3, 8'h03);
    wr(0, 4, 8'h00);
    // clears leftover tx bytes; highest triggers so only the timeout can act
    wr(0, 2, 8'hff);
    i_urb_serial_model.put(0, 8'h77);
    // eight-bit words: (8 * 4 + 12) bits of 16 ticks, one tick a cycle
    for (n = 0; n < 2000 && chan_out[0].rx_service_req_n !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    if (n >= 2000) begin
      bust;
    end
    cmp({15'h0000, n >= 700 && n <= 710}, 16'h0001);
    flg(0, 4'b1100);
    rd(0, 2, d);
    cmp({8'h00, d}, 16'h00cc);
    flg(2, 4'b1010);
    report_and_stop;
  end
endmodule // testbench

//--- test/urb_ready_properties.sv
module urb_ready_props #(
  parameter int CH_N = 4
) (
  input logic ref_clk,
  input logic rstn,
  input logic [4:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic osc_in,
  input logic osc_out,
  input urb_pkg::urb_srl_in_s serial_in [CH_N],
  input urb_pkg::urb_chan_out_s chan_out [CH_N]
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [1:0] up;
  logic acc0;
  logic ev0;
  logic wr00;
  // host access or serial event on channel 0 only
  assign acc0 = (reg_rd && reg_addr == 5'h00) || (reg_wr && reg_addr[4:3] == 2'h0);
  assign ev0 = acc0 || serial_in[0].rx_put || serial_in[0].tx_take;
  assign wr00 = reg_wr && reg_addr == 5'h00;
  // past values right after reset are meaningless for the pin follower
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_osc;
    up == 2'h3 |-> osc_out == ~$past(osc_in);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator output wrong");
  property p_tx_rdy;
    !chan_out[0].tx_avail |-> !chan_out[0].tx_service_req_n;
  endproperty
  a_tx_rdy: assert property (p_tx_rdy) else $error("tx ready high with empty store");
  property p_tx_irq;
    !chan_out[0].tx_avail |-> chan_out[0].irq_tx;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx interrupt low with empty store");
  property p_rx_rise;
    $rose(chan_out[0].rx_service_req_n) |-> $past(acc0) || $past(acc0, 2);
  endproperty
  a_rx_rise: assert property (p_rx_rise) else $error("rx ready rose without pop");
  property p_irq_fall;
    $fell(chan_out[0].irq_rx) |-> $past(ev0) || $past(ev0, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("rx interrupt fell untouched");
  property p_tx_gone;
    $fell(chan_out[0].tx_avail) |-> $past(ev0) || $past(ev0, 2);
  endproperty
  a_tx_gone: assert property (p_tx_gone) else $error("tx store emptied by itself");
  property p_tx_new;
    $rose(chan_out[0].tx_avail) |-> $past(wr00) || $past(wr00, 2);
  endproperty
  a_tx_new: assert property (p_tx_new) else $error("tx store filled from elsewhere");
endmodule // urb_ready_props

bind urb_quad_ready_baud urb_ready_props #(.CH_N(CH_N)) i_urb_ready_props (
  .ref_clk(ref_clk),
  .rstn(rstn),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .osc_in(osc_in),
  .osc_out(osc_out),
  .serial_in(serial_in),
  .chan_out(chan_out)
);

//--- test/urb_serial_model.sv
module urb_serial_model #(
  parameter int CH_N = 4
) (
  input logic ref_clk,
  output urb_pkg::urb_srl_in_s serial_in [CH_N]
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    for (int i = 0; i < CH_N; i++) begin
      serial_in[i] = '0;
    end
  end
  task put(input int c, input logic [7:0] b);
    @(posedge ref_clk);
    serial_in[c].rx_put <= 1'b1;
    serial_in[c].rx_byte <= b;
    @(posedge ref_clk);
    serial_in[c].rx_put <= 1'b0;
    // released byte lines show the inverse so a late sample cannot pass
    serial_in[c].rx_byte <= ~b;
  endtask
  task take(input int c);
    @(posedge ref_clk);
    serial_in[c].tx_take <= 1'b1;
    @(posedge ref_clk);
    serial_in[c].tx_take <= 1'b0;
  endtask
  task busy(input int c, input logic b);
    @(posedge ref_clk);
    serial_in[c].tx_shift_busy <= b;
  endtask
endmodule // urb_serial_model
